/* File: common/omc_pkg.sv */
// Constants, types and register map of the operating mode controller
//
// Contract
// - Reset ends with mode-select pin high: run mode, fetch reset vector at 0xFFFE-0xFFFF.
// - Pin low at power-on reset or after debug force reset: enter background mode.
// - BACKGROUND command, software break or either breakpoint enters background mode.
// - In background mode CPU stays suspended, awaiting serial debug commands.
// - Non-intrusive commands accepted in run and background modes.
// - CPU register access, trace and resume accepted only in background mode.
// - WAIT instruction stops CPU clock; system clocks keep running.
// - Entering wait clears the interrupt mask bit.
// - Interrupt ends wait; CPU stacks context and enters service routine.
// - In wait only BACKGROUND and memory-with-status commands are accepted.
// - Memory-with-status in wait or stop does no access, returns stop/wait error; in stop2, and in stop3 with background off, the code rejects it instead.
// - BACKGROUND command in wait wakes device into background mode.
// - Either stop mode halts bus clock and CPU clock.
// - Stop disabled: stop instruction causes illegal-opcode reset instead.
// - Stop enabled, background enabled: stop3 with debug logic kept running.
// - Background off, both low-voltage bits set, powerdown control 0: stop3, regulator on.
// - Background off, either low-voltage bit 0: stop3 if control 0, stop2 if 1.
// - Stop3 keeps all register, logic, RAM and pin state.
// - Stop3 ends on enabled reset pin or any listed interrupt source.
// - Reset-pin exit fetches reset vector; interrupt exit takes interrupt vector.
// - Both low-voltage bits set at stop: regulator stays active throughout.
// - Converter and bandgap comparator run in stop only if detector enabled at entry.
// - Stop2 exits on wake-up pin, or real-time counter when enabled.
// - Stop2 wake restarts as power-on: module registers reset, reset vector fetched.
// - Stop2 wake sets powerdown flag; flag and pin latch hold until acknowledge written.
package omc_pkg;

  // ==========================================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] OMC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OMC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] OMC_ADDR_ACK = 8'h08;
  localparam logic [7:0] OMC_ADDR_FORCE = 8'h0C;

  // ==========================================================================
  // Field positions
  localparam int OMC_ACK_BIT = 0;
  localparam int OMC_FORCE_BIT = 0;
  localparam int OMC_ST_MODE_LSB = 0;
  localparam int OMC_ST_PARTIAL_POWERDOWN_FLAG_BIT = 8;
  localparam int OMC_ST_LATCH_BIT = 9;
  localparam int OMC_ST_CFG_LSB = 16;

  localparam logic [15:0] OMC_RESET_VECTOR = 16'hFFFE;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    OMC_M_RESET,
    OMC_M_RUN,
    OMC_M_BACKGROUND,
    OMC_M_WAIT,
    OMC_M_STOP3,
    OMC_M_STOP2
  } omc_mode_t;

  typedef enum logic [2:0] {
    OMC_CMD_MEM = 3'h0,
    OMC_CMD_MEM_STATUS = 3'h1,
    OMC_CMD_BDC_REG = 3'h2,
    OMC_CMD_BACKGROUND = 3'h3,
    OMC_CMD_CPU_REG = 3'h4,
    OMC_CMD_TRACE = 3'h5,
    OMC_CMD_GO = 3'h6
  } omc_cmd_t;

  // Control register, bit 0 upward: stop_enable_bit first
  typedef struct packed {
    logic rtc_wake_enable;
    logic reset_pin_enable;
    logic partial_powerdown_control;
    logic low_voltage_stop_enable;
    logic low_voltage_detect_enable;
    logic background_enable_bit;
    logic stop_enable_bit;
  } omc_cfg_t;

  localparam omc_cfg_t OMC_CFG_RESET = '0;

  typedef struct packed {
    logic valid;
    omc_cmd_t cmd;
  } omc_dbg_req_t;

  typedef struct packed {
    logic accept;
    logic reject;
    logic status_error;
    logic mem_access;
  } omc_dbg_rsp_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } omc_wb_req_t;

endpackage : omc_pkg

/* File: logic/omc_mode_ctrl.sv */
// Operating mode controller: reset mode pick, wait, stop3/stop2 and debug command gating
`timescale 1ns/10ps
`default_nettype none
module omc_mode_ctrl
  import omc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire omc_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Reset and pins
  input wire logic por_i,
  input wire logic background_mode_select_pin_i,
  input wire logic reset_pin_n_i,
  input wire logic wakeup_pin_n_i,
  // CPU decode and event sources
  input wire logic wait_exec_i,
  input wire logic stop_exec_i,
  input wire logic software_break_instruction_i,
  input wire logic bdc_breakpoint_i,
  input wire logic dbg_breakpoint_i,
  input wire logic irq_request_i,
  input wire logic [6:0] stop3_wake_src_i,
  input wire logic rtc_wake_i,
  // Debug command path from the background debug controller
  input wire omc_dbg_req_t dbg_req_i,
  output omc_dbg_rsp_t dbg_rsp_o,
  // Mode outputs
  output omc_mode_t mode_o,
  output logic cpu_clk_en_o,
  output logic cpu_suspend_o,
  output logic bus_clk_en_o,
  output logic bdc_clk_en_o,
  output logic vreg_active_o,
  output logic adc_stop_en_o,
  output logic analog_comparator_bandgap_stop_en_o,
  output logic pins_latched_o,
  output logic clear_irq_mask_o,
  output logic irq_resume_o,
  output logic trace_step_o,
  output logic fetch_vector_o,
  output logic [15:0] vector_addr_o,
  output logic illegal_opcode_reset_o,
  output logic module_reset_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    omc_mode_t mode;
    omc_cfg_t cfg;
    logic force_pending;
    logic partial_powerdown_flag;
    logic pins_latched;
    logic stop_bdc;
    logic stop_vreg;
    logic stop_lvd;
    logic [1:0] ms_sync;
    logic [1:0] rst_sync;
    logic [1:0] wk_sync;
    logic cpu_clk_en;
    logic cpu_suspend;
    logic bus_clk_en;
    logic bdc_clk_en;
    logic vreg_active;
    logic adc_stop_en;
    logic analog_comparator_stop_en;
    logic clear_imask;
    logic irq_resume;
    logic trace_step;
    logic fetch_vector;
    logic [15:0] vector_addr;
    logic illegal_reset;
    logic module_reset;
    omc_dbg_rsp_t rsp;
    logic wb_ack;
    logic [31:0] wb_dat;
  } omc_state_t;

  omc_state_t r;
  omc_state_t next_r;

  function automatic logic omc_nonintrusive(input omc_cmd_t c);
    return (c == OMC_CMD_MEM) || (c == OMC_CMD_MEM_STATUS) ||
           (c == OMC_CMD_BDC_REG) || (c == OMC_CMD_BACKGROUND);
  endfunction : omc_nonintrusive

  // Commands that reach memory when the device is awake
  function automatic logic omc_mem_cmd(input omc_cmd_t c);
    return (c == OMC_CMD_MEM) || (c == OMC_CMD_MEM_STATUS);
  endfunction : omc_mem_cmd

  // Answer used while asleep: status reads error out, BACKGROUND is taken
  function automatic omc_dbg_rsp_t omc_sleep_rsp(input omc_cmd_t c);
    omc_dbg_rsp_t s;
    s = '0;
    if (c == OMC_CMD_MEM_STATUS) begin
      s.accept = 1'b1;
      s.status_error = 1'b1;
    end else if (c == OMC_CMD_BACKGROUND) begin
      s.accept = 1'b1;
    end else begin
      s.reject = 1'b1;
    end
    return s;
  endfunction : omc_sleep_rsp

  logic wb_hit;
  logic wr_ok;
  logic ms_high;
  logic rst_pin_active;
  logic wake_pin_active;
  logic dbg_bg;
  logic bg_event;
  logic ack_write;

  always_comb begin
    next_r = r;
    wb_hit = wb_i.cyc && wb_i.stb && !r.wb_ack;
    wr_ok = wb_hit && wb_i.we && wb_i.sel[0];
    ms_high = r.ms_sync[1];
    rst_pin_active = !r.rst_sync[1];
    wake_pin_active = !r.wk_sync[1];
    dbg_bg = dbg_req_i.valid && (dbg_req_i.cmd == OMC_CMD_BACKGROUND);
    bg_event = dbg_bg || software_break_instruction_i || bdc_breakpoint_i || dbg_breakpoint_i;
    ack_write = wr_ok && (wb_i.adr == OMC_ADDR_ACK) && wb_i.dat[OMC_ACK_BIT];

    // Pin synchronisers: only stage 2 is read by logic, stage 1 may be metastable
    next_r.ms_sync = {r.ms_sync[0], background_mode_select_pin_i};
    next_r.rst_sync = {r.rst_sync[0], reset_pin_n_i};
    next_r.wk_sync = {r.wk_sync[0], wakeup_pin_n_i};

    // Single-cycle pulses default low
    next_r.clear_imask = 1'b0;
    next_r.irq_resume = 1'b0;
    next_r.trace_step = 1'b0;
    next_r.fetch_vector = 1'b0;
    next_r.illegal_reset = 1'b0;
    next_r.module_reset = 1'b0;
    next_r.rsp = '0;

    // ========================================================================
    // Wishbone register file
    next_r.wb_ack = wb_hit;
    next_r.wb_dat = '0;
    if (wb_hit && !wb_i.we) begin
      case (wb_i.adr)
        OMC_ADDR_CTRL: begin
          next_r.wb_dat[$bits(omc_cfg_t)-1:0] = r.cfg;
        end
        OMC_ADDR_STATUS: begin
          next_r.wb_dat[OMC_ST_MODE_LSB +: $bits(omc_mode_t)] = r.mode;
          next_r.wb_dat[OMC_ST_PARTIAL_POWERDOWN_FLAG_BIT] = r.partial_powerdown_flag;
          next_r.wb_dat[OMC_ST_LATCH_BIT] = r.pins_latched;
          next_r.wb_dat[OMC_ST_CFG_LSB +: 3] = {r.stop_lvd, r.stop_vreg, r.stop_bdc};
        end
        default: begin
          next_r.wb_dat = '0;
        end
      endcase
    end
    if (wr_ok && wb_i.adr == OMC_ADDR_CTRL) begin
      next_r.cfg = omc_cfg_t'(wb_i.dat[$bits(omc_cfg_t)-1:0]);
    end
    if (ack_write) begin
      // Acknowledge reopens the pin latches and drops the flag
      next_r.partial_powerdown_flag = 1'b0;
      next_r.pins_latched = 1'b0;
    end
    if (wr_ok && wb_i.adr == OMC_ADDR_FORCE && wb_i.dat[OMC_FORCE_BIT]) begin
      // Debug force reset: restart internally and remember why
      next_r.force_pending = 1'b1;
      next_r.module_reset = 1'b1;
      next_r.cfg = OMC_CFG_RESET;
      next_r.mode = OMC_M_RESET;
    end

    // ========================================================================
    // Mode sequencer
    case (r.mode)
      OMC_M_RESET: begin
        // Nothing is decoded while the mode is still being picked
        if (dbg_req_i.valid) begin
          next_r.rsp.reject = 1'b1;
        end
        next_r.force_pending = 1'b0;
        if (!ms_high && (por_i || r.force_pending)) begin
          next_r.mode = OMC_M_BACKGROUND;
        end else begin
          next_r.mode = OMC_M_RUN;
          next_r.fetch_vector = 1'b1;
          next_r.vector_addr = OMC_RESET_VECTOR;
        end
      end
      OMC_M_RUN: begin
        if (dbg_req_i.valid) begin
          next_r.rsp.accept = omc_nonintrusive(dbg_req_i.cmd);
          next_r.rsp.reject = !omc_nonintrusive(dbg_req_i.cmd);
          next_r.rsp.mem_access = omc_mem_cmd(dbg_req_i.cmd);
        end
        if (bg_event) begin
          next_r.mode = OMC_M_BACKGROUND;
        end else if (wait_exec_i) begin
          next_r.mode = OMC_M_WAIT;
          next_r.clear_imask = 1'b1;
        end else if (stop_exec_i) begin
          if (!r.cfg.stop_enable_bit) begin
            // Illegal opcode reset goes through the normal reset pick
            next_r.illegal_reset = 1'b1;
            next_r.module_reset = 1'b1;
            next_r.cfg = OMC_CFG_RESET;
            next_r.mode = OMC_M_RESET;
          end else begin
            // Selection frozen here; later control writes change only the reset-pin and real-time counter wake enables
            next_r.stop_bdc = r.cfg.background_enable_bit;
            next_r.stop_lvd = r.cfg.low_voltage_detect_enable && r.cfg.low_voltage_stop_enable;
            next_r.stop_vreg = r.cfg.background_enable_bit || next_r.stop_lvd;
            if (!r.cfg.background_enable_bit && !next_r.stop_lvd && r.cfg.partial_powerdown_control) begin
              next_r.mode = OMC_M_STOP2;
              next_r.pins_latched = 1'b1;
            end else begin
              next_r.mode = OMC_M_STOP3;
            end
          end
        end
      end
      OMC_M_BACKGROUND: begin
        if (dbg_req_i.valid) begin
          next_r.rsp.accept = 1'b1;
          next_r.rsp.mem_access = omc_mem_cmd(dbg_req_i.cmd);
          if (dbg_req_i.cmd == OMC_CMD_TRACE) begin
            next_r.trace_step = 1'b1;
          end
          if (dbg_req_i.cmd == OMC_CMD_GO) begin
            next_r.mode = OMC_M_RUN;
          end
        end
      end
      OMC_M_WAIT: begin
        if (dbg_req_i.valid) begin
          next_r.rsp = omc_sleep_rsp(dbg_req_i.cmd);
        end
        if (dbg_bg) begin
          next_r.mode = OMC_M_BACKGROUND;
        end else if (irq_request_i) begin
          next_r.mode = OMC_M_RUN;
          next_r.irq_resume = 1'b1;
        end
      end
      OMC_M_STOP3: begin
        // Debug logic only hears commands if it was kept clocked
        if (dbg_req_i.valid) begin
          if (r.stop_bdc) begin
            next_r.rsp = omc_sleep_rsp(dbg_req_i.cmd);
          end else begin
            next_r.rsp.reject = 1'b1;
          end
        end
        if (r.cfg.reset_pin_enable && rst_pin_active) begin
          next_r.module_reset = 1'b1;
          next_r.cfg = OMC_CFG_RESET;
          next_r.mode = OMC_M_RESET;
        end else if (dbg_bg && r.stop_bdc) begin
          next_r.mode = OMC_M_BACKGROUND;
        end else if (|stop3_wake_src_i) begin
          next_r.mode = OMC_M_RUN;
          next_r.irq_resume = 1'b1;
        end
      end
      OMC_M_STOP2: begin
        if (dbg_req_i.valid) begin
          next_r.rsp.reject = 1'b1;
        end
        if (wake_pin_active || (rtc_wake_i && r.cfg.rtc_wake_enable)) begin
          // Power-on style restart; flag and pin latch survive it
          next_r.module_reset = 1'b1;
          next_r.cfg = OMC_CFG_RESET;
          next_r.mode = OMC_M_RUN;
          next_r.fetch_vector = 1'b1;
          next_r.vector_addr = OMC_RESET_VECTOR;
          next_r.partial_powerdown_flag = 1'b1;
          next_r.pins_latched = 1'b1;
        end
      end
      default: begin
        next_r.mode = OMC_M_RESET;
      end
    endcase

    // ========================================================================
    // Clock and power gating follow the next mode
    next_r.cpu_clk_en = (next_r.mode == OMC_M_RUN) || (next_r.mode == OMC_M_BACKGROUND);
    next_r.cpu_suspend = (next_r.mode == OMC_M_BACKGROUND);
    next_r.bus_clk_en = (next_r.mode != OMC_M_STOP3) && (next_r.mode != OMC_M_STOP2);
    next_r.bdc_clk_en = next_r.bus_clk_en || ((next_r.mode == OMC_M_STOP3) && next_r.stop_bdc);
    next_r.vreg_active = next_r.bus_clk_en || ((next_r.mode == OMC_M_STOP3) && next_r.stop_vreg);
    next_r.adc_stop_en = (next_r.mode == OMC_M_STOP3) && next_r.stop_lvd;
    next_r.analog_comparator_stop_en = (next_r.mode == OMC_M_STOP3) && next_r.stop_lvd;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.mode <= OMC_M_RESET;
      r.cfg <= OMC_CFG_RESET;
      // Synchronisers keep sampling so the pin level is known at release
      r.ms_sync <= next_r.ms_sync;
      r.rst_sync <= next_r.rst_sync;
      r.wk_sync <= next_r.wk_sync;
      r.bus_clk_en <= 1'b1;
      r.bdc_clk_en <= 1'b1;
      r.vreg_active <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.wb_dat;
  assign wb_ack_o = r.wb_ack;
  assign dbg_rsp_o = r.rsp;
  assign mode_o = r.mode;
  assign cpu_clk_en_o = r.cpu_clk_en;
  assign cpu_suspend_o = r.cpu_suspend;
  assign bus_clk_en_o = r.bus_clk_en;
  assign bdc_clk_en_o = r.bdc_clk_en;
  assign vreg_active_o = r.vreg_active;
  assign adc_stop_en_o = r.adc_stop_en;
  assign analog_comparator_bandgap_stop_en_o = r.analog_comparator_stop_en;
  assign pins_latched_o = r.pins_latched;
  assign clear_irq_mask_o = r.clear_imask;
  assign irq_resume_o = r.irq_resume;
  assign trace_step_o = r.trace_step;
  assign fetch_vector_o = r.fetch_vector;
  assign vector_addr_o = r.vector_addr;
  assign illegal_opcode_reset_o = r.illegal_reset;
  assign module_reset_o = r.module_reset;

endmodule : omc_mode_ctrl
`default_nettype wire

/* File: test/omc_dbg_host.sv */
// Behavioural background debug host: mode-select pin and serial debug requests
`timescale 1ns/10ps
`default_nettype none
module omc_dbg_host
  import omc_pkg::*;
(
  input wire logic clk_i,
  input wire logic send_i,
  input wire omc_cmd_t cmd_i,
  input wire logic hold_low_i,
  output omc_dbg_req_t dbg_req_o,
  output logic pin_o
);
  // ==========================================================================
  // Host side
  initial begin
    dbg_req_o = '0;
    pin_o = 1'b1;
  end
  // Idle command field toggles so a stale code is never mistaken for a request
  always @(posedge clk_i) begin
    dbg_req_o.valid <= send_i;
    dbg_req_o.cmd <= send_i ? cmd_i : omc_cmd_t'(~dbg_req_o.cmd);
    pin_o <= !hold_low_i;
  end
endmodule : omc_dbg_host
`default_nettype wire

/* File: test/omc_mode_checker.sv */
// Port-level assertions for the operating mode controller
`timescale 1ns/10ps
`default_nettype none
module omc_mode_checker
  import omc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wait_exec_i,
  input wire logic software_break_instruction_i,
  input wire logic bdc_breakpoint_i,
  input wire logic dbg_breakpoint_i,
  input wire logic irq_request_i,
  input wire omc_dbg_req_t dbg_req_i,
  input wire omc_dbg_rsp_t dbg_rsp_o,
  input wire omc_mode_t mode_o,
  input wire logic cpu_clk_en_o,
  input wire logic cpu_suspend_o,
  input wire logic bus_clk_en_o,
  input wire logic clear_irq_mask_o,
  input wire logic irq_resume_o,
  input wire logic fetch_vector_o,
  input wire logic [15:0] vector_addr_o
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic bg_cmd;
  logic bg_evt;
  assign bg_cmd = dbg_req_i.valid && dbg_req_i.cmd == OMC_CMD_BACKGROUND;
  assign bg_evt = bg_cmd || software_break_instruction_i || bdc_breakpoint_i || dbg_breakpoint_i;
  sequence s_run_start;
    mode_o == OMC_M_RUN && fetch_vector_o && vector_addr_o == OMC_RESET_VECTOR;
  endsequence
  sequence s_wait_in;
    mode_o == OMC_M_WAIT && clear_irq_mask_o && !cpu_clk_en_o && bus_clk_en_o;
  endsequence
  // The release edge must be seen, so reset cannot disable this one
  property p_reset_exit;
    disable iff (1'b0) $fell(rst_i) |=> s_run_start or (mode_o == OMC_M_BACKGROUND && cpu_suspend_o);
  endproperty
  property p_bg_entry;
    mode_o == OMC_M_RUN && bg_evt |=> mode_o == OMC_M_BACKGROUND;
  endproperty
  property p_suspend;
    mode_o == OMC_M_BACKGROUND |-> cpu_suspend_o;
  endproperty
  property p_active_only;
    dbg_req_i.valid && dbg_req_i.cmd inside {OMC_CMD_CPU_REG, OMC_CMD_TRACE, OMC_CMD_GO}
      && mode_o != OMC_M_BACKGROUND |=> dbg_rsp_o.reject && !dbg_rsp_o.accept;
  endproperty
  property p_wait_entry;
    mode_o == OMC_M_RUN && wait_exec_i && !bg_evt |=> s_wait_in;
  endproperty
  property p_wait_irq;
    mode_o == OMC_M_WAIT && irq_request_i && !bg_cmd |=> mode_o == OMC_M_RUN && irq_resume_o;
  endproperty
  property p_wait_cmd;
    mode_o == OMC_M_WAIT && dbg_req_i.valid
      && !(dbg_req_i.cmd inside {OMC_CMD_BACKGROUND, OMC_CMD_MEM_STATUS}) |=> dbg_rsp_o.reject;
  endproperty
  property p_status_err;
    mode_o == OMC_M_WAIT && dbg_req_i.valid && dbg_req_i.cmd == OMC_CMD_MEM_STATUS
      |=> dbg_rsp_o.accept && dbg_rsp_o.status_error && !dbg_rsp_o.mem_access;
  endproperty
  property p_stop_clk;
    mode_o inside {OMC_M_STOP3, OMC_M_STOP2} |-> !bus_clk_en_o && !cpu_clk_en_o;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("bad mode after reset");
  a_bg_entry: assert property (p_bg_entry) else $error("no background entry");
  a_suspend: assert property (p_suspend) else $error("cpu not suspended");
  a_active_only: assert property (p_active_only) else $error("active command not refused");
  a_wait_entry: assert property (p_wait_entry) else $error("bad wait entry");
  a_wait_irq: assert property (p_wait_irq) else $error("wait not ended by interrupt");
  a_wait_cmd: assert property (p_wait_cmd) else $error("command not refused in wait");
  a_status_err: assert property (p_status_err) else $error("no status error in wait");
  a_stop_clk: assert property (p_stop_clk) else $error("clocks running in stop");
endmodule : omc_mode_checker
bind omc_mode_ctrl omc_mode_checker chk_u (
  .clk_i, .rst_i, .wait_exec_i, .software_break_instruction_i, .bdc_breakpoint_i, .dbg_breakpoint_i,
  .irq_request_i, .dbg_req_i, .dbg_rsp_o, .mode_o, .cpu_clk_en_o, .cpu_suspend_o, .bus_clk_en_o,
  .clear_irq_mask_o, .irq_resume_o, .fetch_vector_o, .vector_addr_o
);
`default_nettype wire

/* File: test/tb_operating_mode_controller.sv */
// Self-checking testbench of the operating mode controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module tb_operating_mode_controller
  import omc_pkg::*;
;
  // ==========================================================================
  // Signals and design
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  omc_wb_req_t wb = '0;
  logic [4:0] ev = '0;
  logic [6:0] wsrc = '0;
  logic irq = 1'b0, wake_n = 1'b1, send = 1'b0, hold = 1'b0;
  logic por = 1'b1, rst_pin_n = 1'b1;
  logic analog_comparator, trace, mreset, rp;
  omc_cmd_t cmd = OMC_CMD_MEM;
  logic [31:0] wb_dat, rdat;
  logic wb_ack, pin, cpu_en, susp, bus_en, bdc_en, vreg, adc_en, latched, clr_mask, resume, fetch, illegal;
  logic [15:0] vaddr;
  omc_dbg_req_t dreq;
  omc_dbg_rsp_t drsp;
  omc_mode_t mode, m;
  omc_cfg_t cfg;
  logic [31:0] r, seed;
  int bad_count = 0, comparisons = 0, cycles = 0;
  omc_dbg_host host_u (.clk_i(clk_i), .send_i(send), .cmd_i(cmd), .hold_low_i(hold), .dbg_req_o(dreq), .pin_o(pin));
  omc_mode_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .por_i(por), .background_mode_select_pin_i(pin), .reset_pin_n_i(rst_pin_n), .wakeup_pin_n_i(wake_n),
    .wait_exec_i(ev[0]), .stop_exec_i(ev[1]), .software_break_instruction_i(ev[2]), .bdc_breakpoint_i(ev[3]),
    .dbg_breakpoint_i(ev[4]), .irq_request_i(irq), .stop3_wake_src_i(wsrc), .rtc_wake_i(1'b0),
    .dbg_req_i(dreq), .dbg_rsp_o(drsp), .mode_o(mode), .cpu_clk_en_o(cpu_en), .cpu_suspend_o(susp),
    .bus_clk_en_o(bus_en), .bdc_clk_en_o(bdc_en), .vreg_active_o(vreg), .adc_stop_en_o(adc_en),
    .analog_comparator_bandgap_stop_en_o(analog_comparator), .pins_latched_o(latched), .clear_irq_mask_o(clr_mask), .irq_resume_o(resume),
    .trace_step_o(trace), .fetch_vector_o(fetch), .vector_addr_o(vaddr), .illegal_opcode_reset_o(illegal),
    .module_reset_o(mreset));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // ==========================================================================
  // Tasks
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    @(posedge clk_i);
    while (wb_ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rdat = wb_dat;
    wb <= '0;
  endtask : wb_xfer
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev <= 5'(1 << i);
    @(posedge clk_i);
    ev <= '0;
    #1;
  endtask : pulse
  task automatic dbg(input omc_cmd_t c, input logic acc, input logic st);
    @(posedge clk_i);
    send <= 1'b1;
    cmd <= c;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK(drsp.accept, acc)
    `CHK(drsp.reject, !acc)
    `CHK(drsp.status_error, st)
    `CHK(drsp.mem_access, acc && !st && c inside {OMC_CMD_MEM, OMC_CMD_MEM_STATUS})
    `CHK(trace, acc && c == OMC_CMD_TRACE)
  endtask : dbg
  task automatic wait_mode(input omc_mode_t w);
    int n = 0;
    while (mode !== w && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(mode, w)
  endtask : wait_mode
  function automatic omc_mode_t exp_stop(input omc_cfg_t c);
    if (c.background_enable_bit || !c.partial_powerdown_control) return OMC_M_STOP3;
    if (c.low_voltage_detect_enable && c.low_voltage_stop_enable) return OMC_M_STOP3;
    return OMC_M_STOP2;
  endfunction : exp_stop
  // ==========================================================================
  // Scenarios
  initial begin
    seed = 32'hc16d;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK({mode, fetch, vaddr}, {OMC_M_RUN, 1'b1, OMC_RESET_VECTOR})
    wb_xfer(1'b0, OMC_ADDR_CTRL, '0);
    `CHK(rdat, 32'h0)
    wb_xfer(1'b0, 8'h10, '0);
    `CHK(rdat, 32'h0)
    for (int c = 0; c < 7; c++) if (c != 3) dbg(omc_cmd_t'(c), c < 3, 1'b0);
    for (int i = 2; i < 6; i++) begin
      if (i < 5) pulse(i);
      else dbg(OMC_CMD_BACKGROUND, 1'b1, 1'b0);
      `CHK({mode, susp}, {OMC_M_BACKGROUND, 1'b1})
      for (int c = 0; c < 7; c++) dbg(omc_cmd_t'(c), 1'b1, 1'b0);
      `CHK(mode, OMC_M_RUN)
    end
    $display("Test debug commands done");
    for (int k = 0; k < 2; k++) begin
      pulse(0);
      `CHK({mode, clr_mask, cpu_en, bus_en}, {OMC_M_WAIT, 3'b101})
      for (int c = 0; c < 7; c++) if (c != 3) dbg(omc_cmd_t'(c), c == 1, c == 1);
      if (k == 0) begin
        @(posedge clk_i);
        irq <= 1'b1;
        @(posedge clk_i);
        irq <= 1'b0;
        #1;
        `CHK({mode, resume}, {OMC_M_RUN, 1'b1})
      end else begin
        dbg(OMC_CMD_BACKGROUND, 1'b1, 1'b0);
        `CHK(mode, OMC_M_BACKGROUND)
        dbg(OMC_CMD_GO, 1'b1, 1'b0);
      end
    end
    $display("Test wait mode done");
    for (int t = 0; t < 44; t++) begin
      r = $random(seed);
      cfg = omc_cfg_t'({r[6:5], (t < 32) ? 5'(t) : r[4:0]});
      wb_xfer(1'b1, OMC_ADDR_CTRL, 32'(cfg));
      pulse(1);
      m = exp_stop(cfg);
      if (!cfg.stop_enable_bit) begin
        `CHK(illegal, 1'b1)
        `CHK(mreset, 1'b1)
        wait_mode(OMC_M_RUN);
        continue;
      end
      `CHK({mode, cpu_en, bus_en, bdc_en}, {m, 2'b00, cfg.background_enable_bit})
      wb_xfer(1'b1, OMC_ADDR_CTRL, 32'(~cfg));
      `CHK(mode, m)
      if (m == OMC_M_STOP3) begin
        `CHK(vreg, cfg.background_enable_bit | (cfg.low_voltage_detect_enable & cfg.low_voltage_stop_enable))
        `CHK({adc_en, analog_comparator}, {2{cfg.low_voltage_detect_enable & cfg.low_voltage_stop_enable}})
        if (cfg.background_enable_bit) dbg(OMC_CMD_MEM_STATUS, 1'b1, 1'b1);
        // Enable bit was inverted by the write above
        rp = r[10] & !cfg.reset_pin_enable;
        @(posedge clk_i);
        rst_pin_n <= !r[10];
        repeat (3) @(posedge clk_i);
        wsrc <= 7'(1 << (r[9:7] % 7));
        wait_mode(OMC_M_RUN);
        `CHK({fetch, resume}, {rp, !rp})
        @(posedge clk_i);
        wsrc <= '0;
        rst_pin_n <= 1'b1;
      end else begin
        @(posedge clk_i);
        wake_n <= 1'b0;
        wait_mode(OMC_M_RUN);
        `CHK(fetch, 1'b1)
        @(posedge clk_i);
        wake_n <= 1'b1;
        wb_xfer(1'b0, OMC_ADDR_STATUS, '0);
        `CHK({rdat[9:8], latched}, 3'b111)
        wb_xfer(1'b1, OMC_ADDR_ACK, 32'h1);
        wb_xfer(1'b0, OMC_ADDR_STATUS, '0);
        `CHK(rdat[9:8], 2'b00)
      end
    end
    $display("Test stop modes done");
    @(posedge clk_i);
    hold <= 1'b1;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK({mode, susp, fetch}, {OMC_M_BACKGROUND, 2'b10})
    dbg(OMC_CMD_GO, 1'b1, 1'b0);
    @(posedge clk_i);
    por <= 1'b0;
    wb_xfer(1'b1, OMC_ADDR_FORCE, 32'h1);
    wait_mode(OMC_M_BACKGROUND);
    hold <= 1'b0;
    dbg(OMC_CMD_GO, 1'b1, 1'b0);
    $display("Test reset entry done");
    stop_test();
  end
endmodule : tb_operating_mode_controller
`default_nettype wire
